// File: rtl/rtc_bus_if.sv
// parallel memory pins between host and device
`timescale 1ns/100ps
interface rtc_bus_if import rtc_pkg::*; #(
  parameter int ADDR_W = ADDR_WIDTH
) ();
  logic [ADDR_W-1:0] addr;
  logic              e_n;
  logic              g_n;
  logic              w_n;
  logic [7:0]        dq_h;
  logic              dq_h_oe;
  logic [7:0]        dq_d;
  logic              dq_d_oe;
  logic [7:0]        dq;

  // resolved data bus; idle bus floats high
  assign dq = dq_d_oe ? dq_d : (dq_h_oe ? dq_h : 8'hFF);

  modport dev  (input addr, e_n, g_n, w_n, dq, output dq_d, dq_d_oe);
  modport host (output addr, e_n, g_n, w_n, dq_h, dq_h_oe, input dq);
endinterface : rtc_bus_if

// File: rtl/rtc_dev_end.sv
// device end: byte memory with timekeeping copies and clock counters
// Overview of operation
// - write happens while strobe and select low
// - cycle spans later fall to earlier rise
// - host holds address stable through write
// - host keeps output gate high when writing
// - strobe low floats driving data outputs
// - select and strobe together: never drive
// - power fail: deselect, block writes, float
// - power fail mid-write drops only that byte
// - writes blocked for recovery delay after power
// - software freezes copies before reading time
// - time bytes are copies, counters separate
// - freeze bit 6 stops copy updates
// - frozen copies hold count at freeze
// - all copies update in one step
// - first update one second after unfreeze
// - set bit 7 stops updates for loading
// - clearing set bit loads counters, resumes
// - reset clears set and freeze bits
// - copies refreshed each second when unfrozen
// - control byte below seven top time bytes
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/100ps
module rtc_dev_end import rtc_pkg::*; #(
  parameter int ADDR_W  = ADDR_WIDTH,
  parameter int SEC_CYC = SEC_CYCLES,
  parameter int REC_CYC = REC_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic pwr_good,
  rtc_bus_if.dev    bus
);
  localparam int DEPTH = 2 ** ADDR_W;
  localparam logic [ADDR_W-1:0] CTL_A = CTL_OFS[ADDR_W-1:0];

  function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] lo,
                                          input logic [7:0] hi, input logic en);
    if (!en)
      return {1'b0, v};
    if (v >= hi)
      return {1'b1, lo};
    if (v[3:0] >= 4'h9)
      return {1'b0, v[7:4] + 4'h1, 4'h0};
    return {1'b0, v + 8'h01};
  endfunction : bcd_step

  function automatic logic [7:0] month_len(input logic [7:0] m, input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    if (m == 8'h02)
      return leap ? 8'h29 : 8'h28;
    if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11)
      return 8'h30;
    return 8'h31;
  endfunction : month_len

  logic [7:0]        mem_q [DEPTH];
  logic [7:0]        ctl_q, ctl_d;
  logic [7:0]        cnt_q [NUM_TIME];
  logic [7:0]        cnt_d [NUM_TIME];
  logic [31:0]       div_q, div_d;
  logic [31:0]       upd_q, upd_d;
  logic [31:0]       rec_q, rec_d;
  logic              wr_act_q;
  logic [ADDR_W-1:0] wa_q, wa_d;
  logic [7:0]        wd_q, wd_d;
  logic              dq_oe_q, dq_oe_d;
  logic [7:0]        dq_q, dq_d;
  logic              acc_ok, wr_act, commit, freeze, load, tick, upd;
  logic              cp_en, hw_en;
  logic [8:0]        s_sec, s_min, s_hour, s_day, s_date, s_mon, s_year;

  // supply gating and recovery hold-off
  always_comb begin
    if (!pwr_good)
      rec_d = '0;
    else if (rec_q == 32'(REC_CYC))
      rec_d = rec_q;
    else
      rec_d = rec_q + 32'h1;
    acc_ok = pwr_good && (rec_q == 32'(REC_CYC));
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n)
      rec_q <= '0;
    else
      rec_q <= rec_d;
  end

  // host access: capture while active, commit on the ending edge
  always_comb begin
    wr_act = acc_ok && !bus.e_n && !bus.w_n;
    wa_d   = wr_act ? bus.addr : wa_q;
    wd_d   = wr_act ? bus.dq : wd_q;
    // a supply drop ends the cycle without commit; only that byte is lost
    commit = wr_act_q && !wr_act && acc_ok;
    // strobe low or early together with select keeps outputs off
    dq_oe_d = acc_ok && !bus.e_n && !bus.g_n && bus.w_n;
    dq_d    = (bus.addr == CTL_A) ? ctl_q : mem_q[bus.addr];
    ctl_d   = ctl_q;
    if (commit && wa_q == CTL_A)
      ctl_d = wd_q;
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ctl_q    <= CTL_RST;
      wr_act_q <= 1'b0;
      wa_q     <= '0;
      wd_q     <= 8'h00;
      dq_oe_q  <= 1'b0;
      dq_q     <= 8'h00;
    end else begin
      ctl_q    <= ctl_d;
      wr_act_q <= wr_act;
      wa_q     <= wa_d;
      wd_q     <= wd_d;
      dq_oe_q  <= dq_oe_d;
      dq_q     <= dq_d;
    end
  end

  // second divider and copy timer
  // the divider keeps counting while frozen; only copies stop
  always_comb begin
    freeze = ctl_q[CTL_FRZ_BIT] || ctl_q[CTL_SET_BIT];
    load   = ctl_q[CTL_SET_BIT] && !ctl_d[CTL_SET_BIT];
    tick   = div_q == 32'(SEC_CYC - 1);
    div_d  = (tick || load) ? '0 : div_q + 32'h1;
    // copy timer restarts on unfreeze so the next copy lands a second later
    upd    = !freeze && upd_q == 32'(SEC_CYC - 1);
    upd_d  = (freeze || upd) ? '0 : upd_q + 32'h1;
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      div_q <= '0;
      upd_q <= '0;
    end else begin
      div_q <= div_d;
      upd_q <= upd_d;
    end
  end

  // real counters, bcd chain
  always_comb begin
    s_sec  = bcd_step(cnt_q[T_SEC], 8'h00, 8'h59, tick);
    s_min  = bcd_step(cnt_q[T_MIN], 8'h00, 8'h59, s_sec[8]);
    s_hour = bcd_step(cnt_q[T_HOUR], 8'h00, 8'h23, s_min[8]);
    s_day  = bcd_step(cnt_q[T_DAY], 8'h01, 8'h07, s_hour[8]);
    s_date = bcd_step(cnt_q[T_DATE], 8'h01, month_len(cnt_q[T_MONTH], cnt_q[T_YEAR]), s_hour[8]);
    s_mon  = bcd_step(cnt_q[T_MONTH], 8'h01, 8'h12, s_date[8]);
    s_year = bcd_step(cnt_q[T_YEAR], 8'h00, 8'h99, s_mon[8]);
    if (load) begin
      for (int i = 0; i < NUM_TIME; i++)
        cnt_d[i] = mem_q[CTL_A + ADDR_W'(i + 1)];
      cnt_d[T_SEC] = mem_q[CTL_A + ADDR_W'(1)] & SEC_MASK;
    end else begin
      // counters run on regardless of freeze
      cnt_d[T_SEC]   = s_sec[7:0];
      cnt_d[T_MIN]   = s_min[7:0];
      cnt_d[T_HOUR]  = s_hour[7:0];
      cnt_d[T_DAY]   = s_day[7:0];
      cnt_d[T_DATE]  = s_date[7:0];
      cnt_d[T_MONTH] = s_mon[7:0];
      cnt_d[T_YEAR]  = s_year[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cnt_q[T_SEC]   <= 8'h00;
      cnt_q[T_MIN]   <= 8'h00;
      cnt_q[T_HOUR]  <= 8'h00;
      cnt_q[T_DAY]   <= 8'h01;
      cnt_q[T_DATE]  <= 8'h01;
      cnt_q[T_MONTH] <= 8'h01;
      cnt_q[T_YEAR]  <= 8'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // storage strobes for the time copy and the host byte
  always_comb begin
    cp_en = upd;
    hw_en = commit && wa_q != CTL_A;
  end

  // storage has no reset; contents are battery-backed in the real part
  always_ff @(posedge clk_sys) begin
    // copy the count as it stands after this edge, so a copy on a tick is current
    if (cp_en) begin
      for (int i = 0; i < NUM_TIME; i++)
        mem_q[CTL_A + ADDR_W'(i + 1)] <= cnt_d[i];
    end
    // a host byte landing with a copy wins
    if (hw_en)
      mem_q[wa_q] <= wd_q;
  end

  assign bus.dq_d    = dq_q;
  assign bus.dq_d_oe = dq_oe_q;
endmodule : rtc_dev_end

// File: rtl/rtc_host_end.sv
// host end: Avalon-MM command registers driving the parallel memory pins
`timescale 1ns/100ps
module rtc_host_end import rtc_pkg::*; #(
  parameter int ADDR_W  = ADDR_WIDTH,
  parameter int STB_CYC = STB_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  rtc_bus_if.host          bus
);
  rtc_hstate_t       st_q, st_d;
  logic [ADDR_W-1:0] areg_q, areg_d;
  logic [7:0]        wreg_q, wreg_d;
  logic [7:0]        rdat_q, rdat_d;
  logic              isw_q, isw_d;
  logic [7:0]        cnt_q, cnt_d;
  logic              e_n_q, e_n_d, g_n_q, g_n_d, w_n_q, w_n_d, oe_q, oe_d;
  logic              wait_q, wait_d;
  logic [31:0]       rd_q, rd_d;
  logic              acc, take, go;

  // one wait state: read data prepared while waitrequest is high,
  // writes land only at the edge that samples it low
  always_comb begin
    acc    = (avs_read || avs_write) && wait_q;
    take   = avs_write && !wait_q;
    wait_d = !acc;
    go     = take && avs_address == H_CMD_OFS && avs_writedata[CMD_GO_BIT] && st_q == H_IDLE;
    areg_d = areg_q;
    wreg_d = wreg_q;
    rd_d   = rd_q;
    if (take && avs_address == H_ADDR_OFS)
      areg_d = avs_writedata[ADDR_W-1:0];
    else if (take && avs_address == H_WDAT_OFS)
      wreg_d = avs_writedata[7:0];
    if (acc && avs_read) begin
      if (avs_address == H_ADDR_OFS)
        rd_d = 32'(areg_q);
      else if (avs_address == H_WDAT_OFS)
        rd_d = {24'h000000, wreg_q};
      else if (avs_address == H_STAT_OFS)
        rd_d = {16'h0000, rdat_q, 7'h00, st_q != H_IDLE};
      else
        rd_d = 32'h00000000;
    end
  end

  // pin sequencer
  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    isw_d  = isw_q;
    rdat_d = rdat_q;
    e_n_d  = 1'b1;
    g_n_d  = 1'b1;
    w_n_d  = 1'b1;
    oe_d   = 1'b0;
    case (st_q)
      H_IDLE: begin
        if (go) begin
          isw_d = avs_writedata[CMD_WR_BIT];
          st_d  = H_SETUP;
        end
      end
      H_SETUP: begin
        // address settles a cycle before any strobe
        e_n_d = 1'b0;
        w_n_d = !isw_q;
        g_n_d = isw_q;
        oe_d  = isw_q;
        cnt_d = 8'(STB_CYC - 1);
        st_d  = H_STROBE;
      end
      H_STROBE: begin
        e_n_d = 1'b0;
        w_n_d = !isw_q;
        g_n_d = isw_q;
        oe_d  = isw_q;
        cnt_d = cnt_q - 8'h01;
        if (cnt_q == 8'h00) begin
          e_n_d = 1'b1;
          w_n_d = 1'b1;
          g_n_d = 1'b1;
          if (!isw_q)
            rdat_d = bus.dq;
          st_d = H_HOLD;
        end
      end
      H_HOLD: begin
        // data held past the rising strobe
        oe_d = 1'b0;
        st_d = H_IDLE;
      end
      default: st_d = H_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      st_q   <= H_IDLE;
      areg_q <= '0;
      wreg_q <= 8'h00;
      rdat_q <= 8'h00;
      isw_q  <= 1'b0;
      cnt_q  <= 8'h00;
      e_n_q  <= 1'b1;
      g_n_q  <= 1'b1;
      w_n_q  <= 1'b1;
      oe_q   <= 1'b0;
      wait_q <= 1'b1;
      rd_q   <= 32'h00000000;
    end else begin
      st_q   <= st_d;
      // address may only change while idle
      areg_q <= (st_q == H_IDLE) ? areg_d : areg_q;
      wreg_q <= (st_q == H_IDLE) ? wreg_d : wreg_q;
      rdat_q <= rdat_d;
      isw_q  <= isw_d;
      cnt_q  <= cnt_d;
      e_n_q  <= e_n_d;
      g_n_q  <= g_n_d;
      w_n_q  <= w_n_d;
      oe_q   <= oe_d;
      wait_q <= wait_d;
      rd_q   <= rd_d;
    end
  end

  assign bus.addr        = areg_q;
  assign bus.e_n         = e_n_q;
  assign bus.g_n         = g_n_q;
  assign bus.w_n         = w_n_q;
  assign bus.dq_h        = wreg_q;
  assign bus.dq_h_oe     = oe_q;
  assign avs_readdata    = rd_q;
  assign avs_waitrequest = wait_q;
endmodule : rtc_host_end

// File: rtl/rtc_pkg.sv
// shared constants and types for the clock-backed memory link
package rtc_pkg;
  localparam int CLK_NS       = 10;
  localparam int ADDR_WIDTH   = 19;
  localparam int SEC_NS       = 1000000000;
  localparam int SEC_CYCLES   = SEC_NS / CLK_NS;
  // power_recovery_delay figure is not given; plain default
  localparam int REC_NS       = 1000;
  localparam int REC_CYCLES   = (REC_NS + CLK_NS - 1) / CLK_NS;
  // strobe width used by the host for both reads and writes
  localparam int STB_NS       = 70;
  localparam int STB_CYCLES   = (STB_NS + CLK_NS - 1) / CLK_NS;

  localparam logic [18:0] CTL_OFS  = 19'h7FFF8;
  localparam int NUM_TIME          = 7;
  localparam int CTL_SET_BIT       = 7;
  localparam int CTL_FRZ_BIT       = 6;
  localparam logic [7:0] CTL_RST   = 8'h00;
  localparam logic [7:0] SEC_MASK  = 8'h7F;

  // time byte indices, lowest address first
  localparam int T_SEC   = 0;
  localparam int T_MIN   = 1;
  localparam int T_HOUR  = 2;
  localparam int T_DAY   = 3;
  localparam int T_DATE  = 4;
  localparam int T_MONTH = 5;
  localparam int T_YEAR  = 6;

  // host command port, byte offsets on Avalon-MM
  localparam logic [3:0] H_ADDR_OFS = 4'h0;
  localparam logic [3:0] H_WDAT_OFS = 4'h4;
  localparam logic [3:0] H_CMD_OFS  = 4'h8;
  localparam logic [3:0] H_STAT_OFS = 4'hC;
  localparam int CMD_GO_BIT   = 0;
  localparam int CMD_WR_BIT   = 1;
  localparam int STAT_BSY_BIT = 0;
  localparam int STAT_RD_LSB  = 8;

  typedef enum logic [1:0] {
    H_IDLE   = 2'b00,
    H_SETUP  = 2'b01,
    H_STROBE = 2'b11,
    H_HOLD   = 2'b10
  } rtc_hstate_t;
endpackage : rtc_pkg

// File: verification/rtc_link_asserts.sv
// pin-link protocol assertions between host end and device end
`timescale 1ns/100ps
module rtc_link_asserts #(
  parameter int ADDR_W = 19
) (
  input wire logic              clk_sys,
  input wire logic              reset_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic              e_n,
  input wire logic              g_n,
  input wire logic              w_n,
  input wire logic [7:0]        dq_h,
  input wire logic              dq_h_oe,
  input wire logic              dq_d_oe
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  a_addr_settled:
    assert property ($fell(w_n) |-> $stable(addr) && !e_n) else $error("address moved at strobe");
  // strobe length fixed by the default host strobe parameter
  a_strobe_len:
    assert property ($fell(e_n) |-> !e_n [*7] ##1 e_n) else $error("strobe length wrong");
  a_data_hold:
    assert property ($rose(w_n) |-> dq_h_oe && $stable(dq_h) ##1 !dq_h_oe) else $error("write data hold wrong");
  a_addr_held:
    assert property (!e_n && !w_n |=> $stable(addr)) else $error("address moved in write");
  a_gate_high:
    assert property (!w_n |-> g_n) else $error("gate low during write");
  a_no_fight:
    assert property (!(dq_d_oe && dq_h_oe)) else $error("both ends drive data");
  a_strobe_float:
    assert property (!w_n |=> !dq_d_oe) else $error("device drives during strobe");
  a_no_drive:
    assert property ($fell(e_n) && $fell(w_n) |-> !dq_d_oe ##1 !dq_d_oe) else $error("device drove on joint fall");
endmodule : rtc_link_asserts

// File: verification/tb_rtc_sram_write_and_clock_access.sv
// self-checking bench for the host and device ends of the clock memory link
`timescale 1ns/100ps
module tb_rtc_sram_write_and_clock_access import rtc_pkg::*; ;
  localparam int SEC = 200;
  localparam int REC = 40;
  logic        clk_sys, reset_n, pwr_good, avs_read, avs_write, avs_waitrequest;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rs, q, seed;
  logic [7:0]  mem [0:55];
  int          fail_count, num_checks;

  rtc_bus_if #(.ADDR_W(6)) rtc_bus_if_inst ();
  rtc_dev_end #(.ADDR_W(6), .SEC_CYC(SEC), .REC_CYC(REC)) rtc_dev_end_inst (.clk_sys(clk_sys),
    .reset_n(reset_n), .pwr_good(pwr_good), .bus(rtc_bus_if_inst.dev));
  rtc_host_end #(.ADDR_W(6)) rtc_host_end_inst (.clk_sys(clk_sys), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .bus(rtc_bus_if_inst.host));
  rtc_link_asserts #(.ADDR_W(6)) rtc_link_asserts_inst (.clk_sys(clk_sys), .reset_n(reset_n),
    .addr(rtc_bus_if_inst.addr), .e_n(rtc_bus_if_inst.e_n), .g_n(rtc_bus_if_inst.g_n),
    .w_n(rtc_bus_if_inst.w_n), .dq_h(rtc_bus_if_inst.dq_h), .dq_h_oe(rtc_bus_if_inst.dq_h_oe),
    .dq_d_oe(rtc_bus_if_inst.dq_d_oe));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  function automatic logic [31:0] bcd_inc(input logic [7:0] b, input logic [7:0] top);
    if (b == top) return 32'h0;
    if (b[3:0] == 4'h9) return {24'h0, b[7:4] + 4'h1, 4'h0};
    return {24'h0, b + 8'h01};
  endfunction : bcd_inc

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic av(input logic [3:0] a, input logic w, input logic [31:0] d);
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= !w;
    avs_writedata <= d;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    rs = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk_sys);
  endtask : av

  // one pin cycle through the command registers, waits until not busy
  task automatic pin(input logic [5:0] a, input logic [7:0] d, input logic w);
    av(H_ADDR_OFS, 1'b1, {26'h0, a});
    av(H_WDAT_OFS, 1'b1, {24'h0, d});
    av(H_CMD_OFS, 1'b1, {30'h0, w, 1'b1});
    do begin
      av(H_STAT_OFS, 1'b0, 32'h0);
    end while (rs[STAT_BSY_BIT] !== 1'b0);
    q = {24'h0, rs[15:8]};
  endtask : pin

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    #400000;
    fail_count++;
    give_verdict();
  end

  initial begin
    {reset_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
    pwr_good = 1'b1;
    seed = 32'd83677;
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (REC + 2) @(posedge clk_sys);
    av(4'h2, 1'b0, 32'h0);
    chk(rs, 32'h0);
    pin(6'h38, 8'h00, 1'b0);
    chk(q, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 56; i++) begin
      seed = xs(seed);
      mem[i] = (i == 0) ? 8'h00 : (i == 55) ? 8'hFF : seed[7:0];
      pin(i[5:0], mem[i], 1'b1);
    end
    for (int i = 0; i < 56; i++) begin
      pin(i[5:0], 8'h00, 1'b0);
      chk(q, {24'h0, mem[i]});
    end
    $display("test memory done");
    pin(6'h38, 8'h80, 1'b1);
    pin(6'h39, 8'h58, 1'b1);
    pin(6'h3A, 8'h59, 1'b1);
    pin(6'h3B, 8'h23, 1'b1);
    repeat (2 * SEC) @(posedge clk_sys);
    pin(6'h39, 8'h00, 1'b0);
    chk(q, 32'h58);
    pin(6'h38, 8'h00, 1'b1);
    pin(6'h39, 8'h00, 1'b0);
    chk(q, 32'h58);
    // three copies land before the freeze, whichever side of a tick they sample
    repeat (3 * SEC + SEC / 2) @(posedge clk_sys);
    pin(6'h38, 8'h40, 1'b1);
    pin(6'h3A, 8'h00, 1'b0);
    chk(q, bcd_inc(8'h59, 8'h59));
    pin(6'h3B, 8'h00, 1'b0);
    chk(q, bcd_inc(8'h23, 8'h23));
    pin(6'h39, 8'h42, 1'b1);
    repeat (2 * SEC) @(posedge clk_sys);
    pin(6'h39, 8'h00, 1'b0);
    chk(q, 32'h42);
    pin(6'h38, 8'h00, 1'b1);
    pin(6'h39, 8'h00, 1'b0);
    chk(q, 32'h42);
    repeat (SEC) @(posedge clk_sys);
    pin(6'h39, 8'h00, 1'b0);
    chk({31'h0, q !== 32'h42}, 32'h1);
    $display("test clock done");
    pin(6'h38, 8'hC0, 1'b1);
    pin(6'h38, 8'h00, 1'b0);
    chk(q, 32'hC0);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (REC + 2) @(posedge clk_sys);
    pin(6'h38, 8'h00, 1'b0);
    chk(q, 32'h0);
    $display("test second reset done");
    fork
      pin(6'h11, 8'h3C, 1'b1);
      begin
        repeat (12) @(posedge clk_sys);
        pwr_good <= 1'b0;
      end
    join
    pin(6'h10, 8'h00, 1'b0);
    chk(q, 32'hFF);
    pwr_good <= 1'b1;
    pin(6'h12, 8'h99, 1'b1);
    repeat (REC) @(posedge clk_sys);
    pin(6'h10, 8'h00, 1'b0);
    chk(q, {24'h0, mem[16]});
    pin(6'h12, 8'h00, 1'b0);
    chk(q, {24'h0, mem[18]});
    pin(6'h12, 8'h99, 1'b1);
    pin(6'h12, 8'h00, 1'b0);
    chk(q, 32'h99);
    $display("test power done");
    give_verdict();
  end
endmodule : tb_rtc_sram_write_and_clock_access
